// ---- rtl/lbs_pkg.sv ----
// lbs_pkg: shared types and constants for the bank state tracker
package lbs_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int NUM_BANKS  = 4;
    localparam int BANK_W     = 2;
    localparam int BYTE_LANES = 4;
    localparam int DATA_W     = 32;
    localparam int ADDR_W     = 8;

    // ****************************************
    // timing (ns) and derived cycle counts at 20 MHz
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_RCD_NS      = 18;
    localparam int T_RP_NS       = 18;
    localparam int T_MRR_NS      = 100;
    localparam int T_MRW_NS      = 250;
    localparam int T_BURST_NS    = 200;

    // least times round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] RCD_CYC   = CNT_W'(ns_to_cyc(T_RCD_NS));
    localparam logic [CNT_W-1:0] RP_CYC    = CNT_W'(ns_to_cyc(T_RP_NS));
    localparam logic [CNT_W-1:0] MRR_CYC   = CNT_W'(ns_to_cyc(T_MRR_NS));
    localparam logic [CNT_W-1:0] MRW_CYC   = CNT_W'(ns_to_cyc(T_MRW_NS));
    localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(ns_to_cyc(T_BURST_NS));
    localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;

    // ****************************************
    // commands and bank states
    // ****************************************
    typedef enum logic [3:0] {
        LBS_CMD_NOP,
        LBS_CMD_ACT,
        LBS_CMD_RD,
        LBS_CMD_WR,
        LBS_CMD_PRE,
        LBS_CMD_PREA,
        LBS_CMD_BST,
        LBS_CMD_MRR,
        LBS_CMD_MRW,
        LBS_CMD_RESET,
        LBS_CMD_REF
    } lbs_cmd_t;

    typedef enum logic [3:0] {
        LBS_POWER_ON,
        LBS_IDLE,
        LBS_ACTIVATING,
        LBS_ACTIVE,
        LBS_READING,
        LBS_WRITING,
        LBS_RD_AP,
        LBS_WR_AP,
        LBS_PRECHARGING,
        LBS_IDLE_MRR,
        LBS_ACTIVE_MRR,
        LBS_RESETTING,
        LBS_RESET_MRR,
        LBS_MR_WRITING,
        LBS_REFRESHING
    } lbs_state_t;

    typedef struct packed {
        lbs_cmd_t            cmd;
        logic [BANK_W-1:0]   bank;
        logic                ap;
    } lbs_req_t;

    typedef struct packed {
        logic                  valid;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     data;
        logic [BYTE_LANES-1:0] dm;
    } lbs_wdata_t;

endpackage : lbs_pkg

// ---- rtl/lbs_mem.sv ----
// lbs_mem: small byte-masked store with registered read data
`timescale 1ns/100ps
`default_nettype none
module lbs_mem
    import lbs_pkg::*;
(
    // clock
    input  wire logic                  mclk_in,
    // write port
    input  wire logic                  we_in,
    input  wire logic [ADDR_W-1:0]     waddr_in,
    input  wire logic [DATA_W-1:0]     wdata_in,
    input  wire logic [BYTE_LANES-1:0] dm_in,
    // read port
    input  wire logic [ADDR_W-1:0]     raddr_in,
    output var  logic [DATA_W-1:0]     rdata_out
);

    logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

    // a high mask bit leaves the byte untouched
    always_ff @(posedge mclk_in)
    begin
        for (int i = 0; i < BYTE_LANES; i++)
        begin
            if (we_in && !dm_in[i])
                mem_reg[waddr_in][i*8 +: 8] <= wdata_in[i*8 +: 8];
        end
        rdata_out <= mem_reg[raddr_in];
    end

endmodule : lbs_mem
`default_nettype wire

// ---- rtl/lbs_bank_track.sv ----
// lbs_bank_track: per-bank state record and command legality for the DRAM side
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - cross-bank rules hold only with clock enable high on two edges
// - idle after precharge plus tRP; active after activate plus tRCD
// - burst terminate ends only the running burst, never another bank
// - mode read returns bank to idle, active or resetting after tMRR
// - mode write holds bank writing until tMRW, then idle
// - activate or precharge other bank accepted during any burst
// - auto precharge on or off judged alike for legality
// - mode read accepted while a bank is activating
// - mode read accepted while a bank is precharging
// - bank in transition finishes to active or idle on its own timer during mode read
// - reset command from power on enters resetting
// - bytes with mask low are stored, mask high bytes discarded
module lbs_bank_track
    import lbs_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  rst_n_in,
    // command pins
    input  wire logic                  cke_in,
    input  wire lbs_req_t              req_in,
    input  wire lbs_wdata_t            wdata_in,
    input  wire logic [ADDR_W-1:0]     raddr_in,
    // status
    output var  lbs_state_t            bank_state_out [NUM_BANKS],
    output var  logic                  illegal_out,
    output var  logic                  cmd_taken_out,
    output var  logic [DATA_W-1:0]     rdata_out
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic       cke_s1_reg, cke_s2_reg, cke_prev_reg;
    lbs_req_t   req_s1_reg, req_s2_reg;
    lbs_wdata_t wd_s1_reg,  wd_s2_reg;

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cke_s1_reg   <= 1'b0;
            cke_s2_reg   <= 1'b0;
            cke_prev_reg <= 1'b0;
            req_s1_reg   <= '0;
            req_s2_reg   <= '0;
            wd_s1_reg    <= '0;
            wd_s2_reg    <= '0;
        end
        else
        begin
            cke_s1_reg   <= cke_in;
            cke_s2_reg   <= cke_s1_reg;
            cke_prev_reg <= cke_s2_reg;
            req_s1_reg   <= req_in;
            req_s2_reg   <= req_s1_reg;
            wd_s1_reg    <= wdata_in;
            wd_s2_reg    <= wd_s1_reg;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic is_busy_lock(input lbs_state_t s);
        return s inside {LBS_IDLE_MRR, LBS_ACTIVE_MRR, LBS_RESET_MRR, LBS_MR_WRITING, LBS_REFRESHING};
    endfunction : is_busy_lock

    function automatic logic is_burst(input lbs_state_t s);
        return s inside {LBS_READING, LBS_WRITING, LBS_RD_AP, LBS_WR_AP};
    endfunction : is_burst

    function automatic logic is_transit(input lbs_state_t s);
        return s inside {LBS_ACTIVATING, LBS_PRECHARGING, LBS_RD_AP, LBS_WR_AP};
    endfunction : is_transit

    // ****************************************
    // bank state records
    // ****************************************
    lbs_state_t       st_reg   [NUM_BANKS];
    lbs_state_t       st_next  [NUM_BANKS];
    logic [CNT_W-1:0] cnt_reg  [NUM_BANKS];
    logic [CNT_W-1:0] cnt_next [NUM_BANKS];
    lbs_state_t       ret_reg  [NUM_BANKS];
    lbs_state_t       ret_next [NUM_BANKS];
    logic             ill_next, taken_next, ill_reg, taken_reg;
    logic             we_next;

    logic     en;
    lbs_cmd_t cmd;
    logic [BANK_W-1:0] bk;
    logic     all_idle, any_burst, any_lock, any_rd, any_wr, all_pre_ok, all_rst;

    always_comb
    begin
        en         = cke_s2_reg && cke_prev_reg;
        cmd        = req_s2_reg.cmd;
        bk         = req_s2_reg.bank;
        all_idle   = 1'b1;
        any_burst  = 1'b0;
        any_lock   = 1'b0;
        any_rd     = 1'b0;
        any_wr     = 1'b0;
        all_pre_ok = 1'b1;
        all_rst    = 1'b1;
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            all_idle   = all_idle && (st_reg[b] == LBS_IDLE);
            any_burst  = any_burst || is_burst(st_reg[b]);
            any_lock   = any_lock || is_busy_lock(st_reg[b]);
            any_rd     = any_rd || (st_reg[b] inside {LBS_READING, LBS_RD_AP});
            any_wr     = any_wr || (st_reg[b] inside {LBS_WRITING, LBS_WR_AP});
            all_pre_ok = all_pre_ok && (st_reg[b] inside {LBS_IDLE, LBS_ACTIVE, LBS_PRECHARGING});
            all_rst    = all_rst && (st_reg[b] == LBS_RESETTING);
        end
    end

    always_comb
    begin
        ill_next   = 1'b0;
        taken_next = 1'b0;
        we_next    = 1'b0;
        // timers first: each bank advances on its own
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            st_next[b]  = st_reg[b];
            ret_next[b] = ret_reg[b];
            cnt_next[b] = (cnt_reg[b] != CNT_ZERO) ? cnt_reg[b] - CNT_ONE : CNT_ZERO;
            if (cnt_reg[b] == CNT_ONE)
            begin
                case (st_reg[b])
                    LBS_ACTIVATING:  st_next[b] = LBS_ACTIVE;
                    LBS_PRECHARGING: st_next[b] = LBS_IDLE;
                    LBS_READING,
                    LBS_WRITING:     st_next[b] = LBS_ACTIVE;
                    LBS_RD_AP,
                    LBS_WR_AP:
                    begin
                        st_next[b]  = LBS_PRECHARGING;
                        cnt_next[b] = RP_CYC;
                    end
                    LBS_IDLE_MRR,
                    LBS_ACTIVE_MRR,
                    LBS_RESET_MRR:   st_next[b] = ret_reg[b];
                    LBS_MR_WRITING:  st_next[b] = LBS_IDLE;
                    LBS_REFRESHING:  st_next[b] = LBS_IDLE;
                    default:         st_next[b] = st_reg[b];
                endcase
            end
        end
        // commands, only while the clock enable was high on both edges
        if (en && cmd != LBS_CMD_NOP)
        begin
            taken_next = 1'b1;
            if (any_lock)
                ill_next = 1'b1;
            else
            begin
                case (cmd)
                    LBS_CMD_ACT:
                        if (st_reg[bk] == LBS_IDLE)
                        begin
                            st_next[bk]  = LBS_ACTIVATING;
                            cnt_next[bk] = RCD_CYC;
                        end
                        else
                            ill_next = 1'b1;
                    LBS_CMD_RD, LBS_CMD_WR:
                        if (st_reg[bk] inside {LBS_ACTIVE, LBS_READING, LBS_WRITING}
                            && !(cmd == LBS_CMD_WR && any_rd && st_reg[bk] != LBS_READING)
                            && !(cmd == LBS_CMD_RD && any_wr && st_reg[bk] != LBS_WRITING))
                        begin
                            // a new burst replaces any read or write burst without auto precharge in the other banks
                            for (int b = 0; b < NUM_BANKS; b++)
                                if (b != int'(bk) && st_reg[b] inside {LBS_READING, LBS_WRITING})
                                    st_next[b] = LBS_ACTIVE;
                            if (cmd == LBS_CMD_RD)
                                st_next[bk] = req_s2_reg.ap ? LBS_RD_AP : LBS_READING;
                            else
                                st_next[bk] = req_s2_reg.ap ? LBS_WR_AP : LBS_WRITING;
                            cnt_next[bk] = BURST_CYC;
                        end
                        else
                            ill_next = 1'b1;
                    LBS_CMD_PRE:
                        if (st_reg[bk] inside {LBS_IDLE, LBS_ACTIVE})
                        begin
                            st_next[bk]  = LBS_PRECHARGING;
                            cnt_next[bk] = RP_CYC;
                        end
                        else
                            ill_next = 1'b1;
                    LBS_CMD_PREA:
                        if (!all_pre_ok)
                            ill_next = 1'b1;
                        else
                            for (int b = 0; b < NUM_BANKS; b++)
                                if (st_reg[b] != LBS_PRECHARGING)
                                begin
                                    st_next[b]  = LBS_PRECHARGING;
                                    cnt_next[b] = RP_CYC;
                                end
                    LBS_CMD_BST:
                        if (st_reg[bk] inside {LBS_READING, LBS_WRITING})
                        begin
                            st_next[bk]  = LBS_ACTIVE;
                            cnt_next[bk] = CNT_ZERO;
                        end
                        else
                            ill_next = 1'b1;
                    LBS_CMD_MRR:
                        if (any_burst)
                            ill_next = 1'b1;
                        else
                            for (int b = 0; b < NUM_BANKS; b++)
                                if (st_reg[b] inside {LBS_IDLE, LBS_ACTIVE, LBS_RESETTING})
                                begin
                                    ret_next[b] = st_reg[b];
                                    cnt_next[b] = MRR_CYC;
                                    st_next[b]  = (st_reg[b] == LBS_IDLE)   ? LBS_IDLE_MRR :
                                                  (st_reg[b] == LBS_ACTIVE) ? LBS_ACTIVE_MRR : LBS_RESET_MRR;
                                end
                    LBS_CMD_MRW, LBS_CMD_REF:
                        if ((all_idle || (cmd == LBS_CMD_MRW && all_rst)) && !any_burst)
                            for (int b = 0; b < NUM_BANKS; b++)
                            begin
                                st_next[b]  = (cmd == LBS_CMD_MRW) ? LBS_MR_WRITING : LBS_REFRESHING;
                                cnt_next[b] = MRW_CYC;
                            end
                        else
                            ill_next = 1'b1;
                    LBS_CMD_RESET:
                        if (!any_burst)
                            for (int b = 0; b < NUM_BANKS; b++)
                            begin
                                st_next[b]  = LBS_RESETTING;
                                cnt_next[b] = CNT_ZERO;
                            end
                        else
                            ill_next = 1'b1;
                    default: ill_next = 1'b1;
                endcase
            end
        end
        // masked write data into the store while any bank writes
        we_next = wd_s2_reg.valid && any_wr;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int b = 0; b < NUM_BANKS; b++)
            begin
                st_reg[b]  <= LBS_POWER_ON;
                ret_reg[b] <= LBS_IDLE;
                cnt_reg[b] <= CNT_ZERO;
            end
            ill_reg   <= 1'b0;
            taken_reg <= 1'b0;
        end
        else
        begin
            for (int b = 0; b < NUM_BANKS; b++)
            begin
                st_reg[b]  <= st_next[b];
                ret_reg[b] <= ret_next[b];
                cnt_reg[b] <= cnt_next[b];
            end
            ill_reg   <= ill_next;
            taken_reg <= taken_next;
        end
    end

    assign bank_state_out = st_reg;
    assign illegal_out    = ill_reg;
    assign cmd_taken_out  = taken_reg;

    // ****************************************
    // data store
    // ****************************************
    lbs_mem u_mem (
        .mclk_in   (mclk_in),
        .we_in     (we_next),
        .waddr_in  (wd_s2_reg.addr),
        .wdata_in  (wd_s2_reg.data),
        .dm_in     (wd_s2_reg.dm),
        .raddr_in  (raddr_in),
        .rdata_out (rdata_out)
    );
    // ****************************************
    // checks
    // ****************************************
    chk_act_timing: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (st_reg[0] != LBS_ACTIVATING) ##1 (st_reg[0] == LBS_ACTIVATING) |-> ##1 (st_reg[0] == LBS_ACTIVE))
        else $error("bank 0 did not become active after tRCD");
    chk_mrw_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $rose(st_reg[1] == LBS_MR_WRITING) |-> ##[1:6] (st_reg[1] == LBS_IDLE))
        else $error("mode write did not end idle");
    chk_mrr_return: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $rose(st_reg[0] == LBS_ACTIVE_MRR) |-> ##2 (st_reg[0] == LBS_ACTIVE))
        else $error("mode read did not return active");
    chk_lock_nop: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (en && any_lock && cmd != LBS_CMD_NOP) |=> ill_reg)
        else $error("command during mode access not flagged");
    chk_bst_other: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (en && cmd == LBS_CMD_BST && !any_lock && !(st_reg[bk] inside {LBS_READING, LBS_WRITING})) |=> ill_reg)
        else $error("stray burst terminate accepted");
    chk_ref_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (en && cmd == LBS_CMD_REF && !all_idle) |=> (ill_reg && st_reg[0] != LBS_REFRESHING))
        else $error("refresh accepted with a bank not idle");
    chk_cke_gate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!en) |=> !taken_reg)
        else $error("command taken with clock enable low");
    chk_pre_time: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $rose(st_reg[2] == LBS_PRECHARGING) |-> ##[1:3] (st_reg[2] != LBS_PRECHARGING))
        else $error("precharge did not complete");
    cov_read: cover property (@(posedge mclk_in) $rose(st_reg[0] == LBS_READING));
    cov_mrw: cover property (@(posedge mclk_in) $rose(st_reg[0] == LBS_MR_WRITING));
    cov_ill: cover property (@(posedge mclk_in) ill_reg);

endmodule : lbs_bank_track
`default_nettype wire

// ---- sim/lbs_ctrl_model.sv ----
// lbs_ctrl_model: controller side model driving commands and write beats
`timescale 1ns/100ps
`default_nettype none
module lbs_ctrl_model
    import lbs_pkg::*;
(
    // clock
    input  wire logic       mclk_in,
    // command pins
    output var  logic       cke_out,
    output var  lbs_req_t   req_out,
    output var  lbs_wdata_t wdata_out
);
    initial
    begin
        cke_out   = 1'b1;
        req_out   = '{LBS_CMD_NOP, 2'h0, 1'b0};
        wdata_out = '{1'b0, 8'h00, 32'h0, 4'h0};
    end

    // up to two commands on consecutive cycles, NOP on every other cycle
    task automatic issue(input lbs_req_t r1, input lbs_req_t r2, input logic two);
        @(negedge mclk_in);
        req_out = r1;
        @(negedge mclk_in);
        req_out = two ? r2 : '{LBS_CMD_NOP, 2'h0, 1'b0};
        if (two)
        begin
            @(negedge mclk_in);
            req_out = '{LBS_CMD_NOP, 2'h0, 1'b0};
        end
    endtask : issue

    // released data lines show inverted values, not the last beat
    task automatic beat(input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
        @(negedge mclk_in);
        wdata_out = '{1'b1, a, d, m};
        @(negedge mclk_in);
        wdata_out = '{1'b0, ~a, ~d, ~m};
    endtask : beat
endmodule : lbs_ctrl_model
`default_nettype wire

// ---- sim/tb_lbs_bank_track.sv ----
// tb_lbs_bank_track: self-checking bench for the bank state tracker
`timescale 1ns/100ps
`default_nettype none
module tb_lbs_bank_track
    import lbs_pkg::*;
;
    logic        mclk, rst_n, cke, ill, taken;
    lbs_req_t    req;
    lbs_wdata_t  wd;
    logic [7:0]  raddr;
    logic [31:0] rdata;
    lbs_state_t  st [NUM_BANKS];
    int          n_errors, samples_checked;

    lbs_ctrl_model ctrl_u (.mclk_in(mclk), .cke_out(cke), .req_out(req), .wdata_out(wd));
    lbs_bank_track dut_u (.mclk_in(mclk), .rst_n_in(rst_n), .cke_in(cke), .req_in(req),
        .wdata_in(wd), .raddr_in(raddr), .bank_state_out(st), .illegal_out(ill),
        .cmd_taken_out(taken), .rdata_out(rdata));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic bank(input int b, input lbs_state_t e);
        chk(32'(st[b]), 32'(e));
    endtask : bank

    task automatic all_st(input lbs_state_t e);
        for (int b = 0; b < NUM_BANKS; b++)
            bank(b, e);
    endtask : all_st

    // pulses stand one cycle, so poll every edge under a bound
    task automatic resp(input logic e1, input logic two, input logic e2);
        int i;
        for (i = 0; i < 10; i++)
        begin
            cyc(1);
            if (taken === 1'b1 || ill === 1'b1)
                break;
        end
        if (i == 10)
        begin
            n_errors++;
            results();
        end
        chk(32'(ill), 32'(e1));
        if (two)
        begin
            cyc(1);
            chk(32'(ill), 32'(e2));
            chk(32'(taken), 32'h1);
        end
    endtask : resp

    task automatic send(input lbs_cmd_t c, input logic [1:0] b, input logic ap, input logic e);
        ctrl_u.issue('{c, b, ap}, '{LBS_CMD_NOP, 2'h0, 1'b0}, 1'b0);
        resp(e, 1'b0, 1'b0);
    endtask : send

    task automatic pair(input lbs_req_t r1, input lbs_req_t r2, input logic e2);
        ctrl_u.issue(r1, r2, 1'b1);
        resp(1'b0, 1'b1, e2);
    endtask : pair

    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_init();
        send(LBS_CMD_RESET, 2'h0, 1'b0, 1'b0);
        all_st(LBS_RESETTING);
        send(LBS_CMD_MRR, 2'h0, 1'b0, 1'b0);
        bank(0, LBS_RESET_MRR);
        cyc(int'(MRR_CYC) + 1);
        all_st(LBS_RESETTING);
        send(LBS_CMD_MRW, 2'h0, 1'b0, 1'b0);
        all_st(LBS_MR_WRITING);
        send(LBS_CMD_ACT, 2'h0, 1'b0, 1'b1);
        cyc(int'(MRW_CYC) + 1);
        all_st(LBS_IDLE);
    endtask : s_init

    task automatic s_cross();
        send(LBS_CMD_ACT, 2'h0, 1'b0, 1'b0);
        send(LBS_CMD_ACT, 2'h1, 1'b0, 1'b0);
        cyc(2);
        bank(1, LBS_ACTIVE);
        send(LBS_CMD_MRW, 2'h0, 1'b0, 1'b1);
        send(LBS_CMD_REF, 2'h0, 1'b0, 1'b1);
        send(LBS_CMD_BST, 2'h0, 1'b0, 1'b1);
        pair('{LBS_CMD_RD, 2'h0, 1'b0}, '{LBS_CMD_WR, 2'h1, 1'b0}, 1'b1);
        cyc(6);
        pair('{LBS_CMD_WR, 2'h0, 1'b0}, '{LBS_CMD_RD, 2'h1, 1'b0}, 1'b1);
        cyc(6);
        pair('{LBS_CMD_RD, 2'h0, 1'b0}, '{LBS_CMD_BST, 2'h0, 1'b0}, 1'b0);
        bank(0, LBS_ACTIVE);
        pair('{LBS_CMD_RD, 2'h0, 1'b1}, '{LBS_CMD_PRE, 2'h1, 1'b0}, 1'b0);
        bank(0, LBS_RD_AP);
        cyc(10);
        bank(0, LBS_IDLE);
        bank(1, LBS_IDLE);
        send(LBS_CMD_ACT, 2'h0, 1'b0, 1'b0);
        pair('{LBS_CMD_ACT, 2'h2, 1'b0}, '{LBS_CMD_MRR, 2'h0, 1'b0}, 1'b0);
        bank(0, LBS_ACTIVE_MRR);
        cyc(int'(MRR_CYC) + 2);
        bank(0, LBS_ACTIVE);
        bank(2, LBS_ACTIVE);
        bank(3, LBS_IDLE);
    endtask : s_cross

    task automatic s_mask();
        ctrl_u.issue('{LBS_CMD_WR, 2'h2, 1'b0}, '{LBS_CMD_NOP, 2'h0, 1'b0}, 1'b0);
        ctrl_u.beat(8'h05, 32'h11223344, 4'h0);
        ctrl_u.beat(8'h05, 32'hAABBCCDD, 4'h5);
        @(negedge mclk);
        raddr = 8'h05;
        cyc(8);
        chk(rdata, 32'hAA22CC44);
    endtask : s_mask

    task automatic s_cke();
        @(negedge mclk);
        ctrl_u.cke_out = 1'b0;
        ctrl_u.issue('{LBS_CMD_ACT, 2'h1, 1'b0}, '{LBS_CMD_NOP, 2'h0, 1'b0}, 1'b0);
        cyc(8);
        bank(1, LBS_IDLE);
        @(negedge mclk);
        ctrl_u.cke_out = 1'b1;
        cyc(4);
    endtask : s_cke

    task automatic s_all();
        send(LBS_CMD_PREA, 2'h0, 1'b0, 1'b0);
        all_st(LBS_PRECHARGING);
        cyc(1);
        all_st(LBS_IDLE);
        send(LBS_CMD_REF, 2'h0, 1'b0, 1'b0);
        all_st(LBS_REFRESHING);
        cyc(int'(MRW_CYC) + 1);
        all_st(LBS_IDLE);
    endtask : s_all

    initial
    begin
        n_errors        = 0;
        samples_checked = 0;
        rst_n           = 1'b0;
        raddr           = 8'h00;
        cyc(20);
        all_st(LBS_POWER_ON);
        @(negedge mclk);
        rst_n = 1'b1;
        cyc(4);
        s_init();
        s_cross();
        s_mask();
        s_cke();
        s_all();
        results();
    end
endmodule : tb_lbs_bank_track
`default_nettype wire
